// [hdl/sqv_regs.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Two-bit field maps priority to two queues
// - Discard bit set confines frames to membership
// - Discard clear leaves single-destination frames unrestricted
// - Discard clear, mirrored single-destination frame dropped
// - Read-only free block count, idle 0x3F7
// - Staging window 0x0400 to 0x04FF
// - Word0 top bit marks entry valid
// - Forward option selects entry's own port map
// - Three-bit entry priority, bits 26:24
// - Three-bit spanning tree index, bits 14:12
// - Seven-bit filter identifier, bits 6:0
// - Action code with self-clearing start bit
// - Entry forward bits apply only with option
module sqv_regs
  import sqv_pkg::*;
#(
  parameter int TABLE_DEPTH = 64
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [sqv_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [sqv_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [sqv_pkg::FREE_CNT_W-1:0] FREE_BLOCKS_I,
  input wire logic MIRROR_EN_I,
  input wire logic [1:0] FRAME_PRIO_I,
  input wire logic [11:0] FRAME_VID_I,
  input wire logic [sqv_pkg::NPORTS-1:0] DEST_MAP_I,
  input wire logic [sqv_pkg::NPORTS-1:0] MEMBER_MAP_I,
  input wire logic MIRRORED_I,
  output logic HIGH_QUEUE_O,
  output logic [sqv_pkg::NPORTS-1:0] FWD_MAP_O,
  output logic [sqv_pkg::FID_W-1:0] FRAME_FID_O,
  output logic [2:0] FRAME_VPRIO_O,
  output logic [2:0] FRAME_MST_O
);
  import sqv_pkg::*;

  localparam int IDX_W = $clog2(TABLE_DEPTH);

  if (TABLE_DEPTH < 2 || TABLE_DEPTH > 4096 ||
      (TABLE_DEPTH & (TABLE_DEPTH - 1)) != 0) begin : g_depth_check
    $error("TABLE_DEPTH must be a power of two in 2..4096");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a == QUEUE_CTRL_ADDR) || (a == FREE_BLOCKS_ADDR);
    hit = hit || (a >= LOOKUP_WIN_LO && a <= LOOKUP_WIN_HI && a[1:0] == 2'h0);
    return hit;
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] rw);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res & rw;
  endfunction : merge

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;

  assign S_AXI_AWREADY_O = !aw_held_reg && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_held_reg && !S_AXI_BVALID_O;
  assign wr_fire = aw_held_reg && w_held_reg;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA_I;
        wstrb_reg <= S_AXI_WSTRB_I;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and staging registers
  // ----------------------------------------------------------------
  logic [31:0] qctrl_reg;
  logic [31:0] word0_reg;
  logic [NPORTS-1:0] untag_reg;
  logic [NPORTS-1:0] pfwd_reg;
  logic [INDEX_W-1:0] index_reg;
  logic start_reg;
  logic [1:0] action_reg;
  sqv_tbl_e state_reg;
  logic [IDX_W-1:0] clr_ptr_reg;
  logic [ENTRY_W-1:0] rd_entry;
  logic load_entry;
  logic done;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      qctrl_reg <= QUEUE_CTRL_RST;
    end else if (wr_fire && awaddr_reg == QUEUE_CTRL_ADDR) begin
      qctrl_reg <= merge(qctrl_reg, wdata_reg, wstrb_reg, QUEUE_CTRL_RW);
    end
  end

  // Table read returns entry into staging words, bus writes otherwise
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      word0_reg <= '0;
      untag_reg <= '0;
      pfwd_reg <= '0;
    end else if (load_entry) begin
      word0_reg <= {rd_entry[16], 3'h0, rd_entry[15:12], 8'h00, 1'b0,
                    rd_entry[11:9], 5'h00, rd_entry[8:2]};
      untag_reg <= '0;
      pfwd_reg <= {rd_entry[1:0], 1'b0};
    end else if (wr_fire) begin
      case (awaddr_reg)
        VLAN_WORD0_ADDR: word0_reg <= merge(word0_reg, wdata_reg, wstrb_reg, WORD0_RW);
        VLAN_WORD1_ADDR: begin
          if (wstrb_reg[0]) begin
            untag_reg <= wdata_reg[NPORTS-1:0];
          end
        end
        VLAN_WORD2_ADDR: begin
          if (wstrb_reg[0]) begin
            pfwd_reg <= wdata_reg[NPORTS-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Index and access control share one word: index low, start/action high
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      index_reg <= '0;
      action_reg <= ACT_NONE;
      start_reg <= 1'b0;
    end else begin
      if (wr_fire && awaddr_reg == VLAN_INDEX_ADDR) begin
        if (wstrb_reg[0]) begin
          index_reg[7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          index_reg[INDEX_W-1:8] <= wdata_reg[INDEX_W-1:8];
        end
        if (wstrb_reg[3] && !start_reg) begin
          action_reg <= wdata_reg[ACTION_LSB +: 2];
          start_reg <= wdata_reg[START_BIT];
        end
      end
      // Completion must clear start even when a bus write lands in the same cycle
      if (done) begin
        start_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // VLAN table engine
  // ----------------------------------------------------------------
  logic [ENTRY_W-1:0] table_mem [TABLE_DEPTH];
  logic [IDX_W-1:0] tbl_idx;
  logic [ENTRY_W-1:0] lk_entry;

  assign tbl_idx = index_reg[IDX_W-1:0];
  assign rd_entry = table_mem[tbl_idx];
  assign load_entry = (state_reg == ST_READ);
  assign done = (state_reg == ST_WRITE) || (state_reg == ST_READ) ||
                (state_reg == ST_CLEAR && clr_ptr_reg == IDX_W'(TABLE_DEPTH - 1));

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= ST_IDLE;
      clr_ptr_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          clr_ptr_reg <= '0;
          if (start_reg) begin
            case (action_reg)
              ACT_WRITE: state_reg <= ST_WRITE;
              ACT_READ: state_reg <= ST_READ;
              ACT_CLEAR: state_reg <= ST_CLEAR;
              default: state_reg <= ST_WRITE;
            endcase
          end
        end
        ST_CLEAR: begin
          clr_ptr_reg <= clr_ptr_reg + 1'b1;
          if (done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Write slot reused as no-op when the action code is none
  always_ff @(posedge CORE_CLK_I) begin
    if (state_reg == ST_WRITE && action_reg == ACT_WRITE) begin
      table_mem[tbl_idx] <= {word0_reg[VALID_BIT], word0_reg[FWD_OPT_BIT],
                             word0_reg[VPRIO_LSB +: 3], word0_reg[MST_LSB +: 3],
                             word0_reg[FID_LSB +: FID_W], pfwd_reg[2:1]};
    end else if (state_reg == ST_CLEAR) begin
      table_mem[clr_ptr_reg] <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Frame path
  // ----------------------------------------------------------------
  logic [NPORTS-1:0] lk_map;
  logic [NPORTS-1:0] fwd_next;
  logic high_next;

  assign lk_entry = table_mem[FRAME_VID_I[IDX_W-1:0]];
  assign lk_map = {lk_entry[1:0], 1'b0};

  sqv_fwd_filter u_filter (
    .prio_map_i(qctrl_reg[PRIO_MAP_LSB +: 2]),
    .ucast_discard_i(qctrl_reg[UCAST_DISC_BIT]),
    .mirror_en_i(MIRROR_EN_I),
    .frame_prio_i(FRAME_PRIO_I),
    .dest_map_i(DEST_MAP_I),
    .member_map_i(MEMBER_MAP_I),
    .mirrored_i(MIRRORED_I),
    .entry_valid_i(lk_entry[16]),
    .fwd_opt_i(lk_entry[15]),
    .entry_map_i(lk_map),
    .high_queue_o(high_next),
    .fwd_map_o(fwd_next)
  );

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      HIGH_QUEUE_O <= 1'b0;
      FWD_MAP_O <= '0;
      FRAME_FID_O <= '0;
      FRAME_VPRIO_O <= '0;
      FRAME_MST_O <= '0;
    end else begin
      HIGH_QUEUE_O <= high_next;
      FWD_MAP_O <= fwd_next;
      FRAME_FID_O <= lk_entry[8:2];
      FRAME_VPRIO_O <= lk_entry[14:12];
      FRAME_MST_O <= lk_entry[11:9];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    case (S_AXI_ARADDR_I)
      QUEUE_CTRL_ADDR: rd_word = qctrl_reg;
      FREE_BLOCKS_ADDR: rd_word = {5'h00, FREE_BLOCKS_I, 16'h0000};
      VLAN_WORD0_ADDR: rd_word = word0_reg;
      VLAN_WORD1_ADDR: rd_word = {29'h0000_0000, untag_reg};
      VLAN_WORD2_ADDR: rd_word = {29'h0000_0000, pfwd_reg};
      VLAN_INDEX_ADDR: rd_word = {start_reg, 5'h00, action_reg, 8'h00, 4'h0, index_reg};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= '0;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_word;
      S_AXI_RRESP_O <= is_mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  prio_reset_a: assert property (@(posedge CORE_CLK_I)
    $rose(RESETN_I) |-> qctrl_reg[PRIO_MAP_LSB +: 2] == MAP_P23 && qctrl_reg[UCAST_DISC_BIT])
    else $error("queue control reset value wrong");
  member_confine_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    qctrl_reg[UCAST_DISC_BIT] |=> (FWD_MAP_O & ~$past(MEMBER_MAP_I)) == '0)
    else $error("frame left membership ports");
  mirror_drop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    !qctrl_reg[UCAST_DISC_BIT] && MIRROR_EN_I && MIRRORED_I && $countones(DEST_MAP_I) == 1
    |=> FWD_MAP_O == '0)
    else $error("mirrored single frame not dropped");
  free_count_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == FREE_BLOCKS_ADDR
    |=> S_AXI_RDATA_O == {5'h00, $past(FREE_BLOCKS_I), 16'h0000})
    else $error("free block count read wrong");
  start_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(start_reg) && action_reg != ACT_CLEAR |-> ##[1:3] !start_reg)
    else $error("start bit not cleared");
  high_queue_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    qctrl_reg[PRIO_MAP_LSB +: 2] == MAP_P3 && FRAME_PRIO_I != 2'h3 |=> !HIGH_QUEUE_O)
    else $error("low priority sent to high queue");
  reserved_zero_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    S_AXI_RVALID_O && $past(S_AXI_ARADDR_I) == VLAN_WORD0_ADDR |-> S_AXI_RDATA_O[30:28] == 3'h0)
    else $error("reserved bits not zero");
  entry_map_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    qctrl_reg[UCAST_DISC_BIT] && lk_entry[16] && lk_entry[15]
    |=> FWD_MAP_O == ($past(lk_map) & $past(MEMBER_MAP_I)))
    else $error("entry port map not used");
endmodule : sqv_regs

// [hdl/sqv_pkg.sv]
package sqv_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] QUEUE_CTRL_ADDR = 12'h0390;
  localparam logic [11:0] FREE_BLOCKS_ADDR = 12'h03ac;
  localparam logic [11:0] VLAN_WORD0_ADDR = 12'h0400;
  localparam logic [11:0] VLAN_WORD1_ADDR = 12'h0404;
  localparam logic [11:0] VLAN_WORD2_ADDR = 12'h0408;
  localparam logic [11:0] VLAN_INDEX_ADDR = 12'h040c;
  localparam logic [11:0] LOOKUP_WIN_LO = 12'h0400;
  localparam logic [11:0] LOOKUP_WIN_HI = 12'h04ff;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int PRIO_MAP_LSB = 6;
  localparam int UCAST_DISC_BIT = 1;
  localparam int FREE_CNT_LSB = 16;
  localparam int FREE_CNT_W = 11;
  localparam int VALID_BIT = 31;
  localparam int FWD_OPT_BIT = 27;
  localparam int VPRIO_LSB = 24;
  localparam int MST_LSB = 12;
  localparam int FID_LSB = 0;
  localparam int FID_W = 7;
  localparam int START_BIT = 31;
  localparam int ACTION_LSB = 24;
  localparam int INDEX_W = 12;
  localparam int NPORTS = 3;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] QUEUE_CTRL_RST = 32'h0000_0082;
  localparam logic [31:0] QUEUE_CTRL_RW = 32'h0000_00ff;
  localparam logic [31:0] WORD0_RW = 32'h8f00_707f;
  localparam logic [10:0] FREE_BLOCKS_MAX = 11'h3f7;
  localparam logic [1:0] MAP_P3 = 2'h0;
  localparam logic [1:0] MAP_P23 = 2'h2;
  localparam logic [1:0] MAP_P123 = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_WRITE = 2'h1;
  localparam logic [1:0] ACT_READ = 2'h2;
  localparam logic [1:0] ACT_CLEAR = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ENTRY_W = 17;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_CLEAR = 4'b1000
  } sqv_tbl_e;
endpackage : sqv_pkg

// [hdl/sqv_fwd_filter.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Forwarding decision for one frame
// ------------------------------------------------------------------
module sqv_fwd_filter
  import sqv_pkg::*;
(
  input wire logic [1:0] prio_map_i,
  input wire logic ucast_discard_i,
  input wire logic mirror_en_i,
  input wire logic [1:0] frame_prio_i,
  input wire logic [sqv_pkg::NPORTS-1:0] dest_map_i,
  input wire logic [sqv_pkg::NPORTS-1:0] member_map_i,
  input wire logic mirrored_i,
  input wire logic entry_valid_i,
  input wire logic fwd_opt_i,
  input wire logic [sqv_pkg::NPORTS-1:0] entry_map_i,
  output logic high_queue_o,
  output logic [sqv_pkg::NPORTS-1:0] fwd_map_o
);
  logic single_dest;
  logic [NPORTS-1:0] base_map;

  always_comb begin
    case (prio_map_i)
      MAP_P3: high_queue_o = (frame_prio_i == 2'h3);
      MAP_P123: high_queue_o = (frame_prio_i != 2'h0);
      default: high_queue_o = frame_prio_i[1];
    endcase
  end

  assign single_dest = ($countones(dest_map_i) == 1);

  always_comb begin
    // Valid entry with the option set uses its own port map
    if (entry_valid_i && fwd_opt_i) begin
      base_map = entry_map_i;
    end else begin
      base_map = dest_map_i;
    end
    if (ucast_discard_i) begin
      fwd_map_o = base_map & member_map_i;
    end else if (single_dest && mirror_en_i && mirrored_i) begin
      fwd_map_o = '0;
    end else if (single_dest) begin
      fwd_map_o = base_map;
    end else begin
      fwd_map_o = base_map & member_map_i;
    end
  end
endmodule : sqv_fwd_filter

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import sqv_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [FREE_CNT_W-1:0] free_blk = 11'h3f7;
  logic mir_en = 1'b0;
  logic [1:0] prio = '0;
  logic [11:0] vid = '0;
  logic [2:0] dest = '0;
  logic [2:0] member = '0;
  logic mirrored = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, high_q;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [2:0] fwd_map, vprio, mst;
  logic [6:0] filter_identifier;
  int n_errors = 0;
  int samples_checked = 0;
  logic [1:0] codes [3] = '{MAP_P3, MAP_P23, MAP_P123};
  int thr [3] = '{3, 2, 1};

  always #5 clk = ~clk;

  sqv_regs #(.TABLE_DEPTH(4)) dut (
    .CORE_CLK_I(clk), .RESETN_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .FREE_BLOCKS_I(free_blk),
    .MIRROR_EN_I(mir_en), .FRAME_PRIO_I(prio), .FRAME_VID_I(vid), .DEST_MAP_I(dest),
    .MEMBER_MAP_I(member), .MIRRORED_I(mirrored), .HIGH_QUEUE_O(high_q),
    .FWD_MAP_O(fwd_map), .FRAME_FID_O(filter_identifier), .FRAME_VPRIO_O(vprio), .FRAME_MST_O(mst)
  );

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: register value %h, wanted %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_port(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: frame output %h, wanted %h", $time, got, exp);
    end
  endtask : chk_port

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) begin
      n_errors++;
      $display("unexpected at %0t: write answer missing", $time);
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) begin
      n_errors++;
      $display("unexpected at %0t: read answer missing", $time);
    end
  endtask : axi_read

  // Start a table action and poll until the start bit drops
  task automatic tbl_act(input logic [1:0] act, input logic [11:0] idx);
    logic [31:0] v;
    int n;
    axi_write(VLAN_INDEX_ADDR, {1'b1, 5'h00, act, 12'h000, idx}, rsp);
    n = 0;
    do begin
      axi_read(VLAN_INDEX_ADDR, v, rsp);
      n++;
    end while (v[START_BIT] !== 1'b0 && n < 20);
    chk_reg(32'(v[START_BIT]), 32'h0000_0000);
  endtask : tbl_act

  task automatic frame(input logic [11:0] v, input logic [1:0] p, input logic [2:0] d,
                       input logic [2:0] m, input logic me, input logic mi);
    @(posedge clk);
    vid <= v;
    prio <= p;
    dest <= d;
    member <= m;
    mir_en <= me;
    mirrored <= mi;
    repeat (2) @(posedge clk);
    #1;
  endtask : frame

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    axi_read(QUEUE_CTRL_ADDR, rd, rsp);
    chk_reg(rd, 32'h0000_0082);
    axi_read(FREE_BLOCKS_ADDR, rd, rsp);
    chk_reg(rd, 32'h03f7_0000);
    free_blk <= 11'h123;
    axi_write(FREE_BLOCKS_ADDR, 32'hffff_ffff, rsp);
    axi_read(FREE_BLOCKS_ADDR, rd, rsp);
    chk_reg(rd, 32'h0123_0000);
    axi_write(QUEUE_CTRL_ADDR, 32'hffff_ffff, rsp);
    axi_read(QUEUE_CTRL_ADDR, rd, rsp);
    chk_reg(rd, 32'h0000_00ff);
    axi_write(VLAN_WORD0_ADDR, 32'hffff_ffff, rsp);
    axi_read(VLAN_WORD0_ADDR, rd, rsp);
    chk_reg(rd, 32'h8f00_707f);
    axi_write(VLAN_WORD1_ADDR, 32'hffff_ffff, rsp);
    axi_read(VLAN_WORD1_ADDR, rd, rsp);
    chk_reg(rd, 32'h0000_0007);
    axi_read(12'h04f0, rd, rsp);
    chk_reg({rd[31:2], rsp}, {30'h0, RESP_OKAY});
    axi_read(12'h0500, rd, rsp);
    chk_reg({rd[31:2], rsp}, {30'h0, RESP_SLVERR});
    axi_write(12'h0100, 32'h1234_5678, rsp);
    chk_reg(32'(rsp), 32'(RESP_SLVERR));
    // Two entries: own map off, own map on
    tbl_act(ACT_CLEAR, 12'h000);
    axi_write(VLAN_WORD0_ADDR, 32'h8500_302a, rsp);
    axi_write(VLAN_WORD2_ADDR, 32'h0000_0000, rsp);
    tbl_act(ACT_WRITE, 12'h001);
    axi_write(VLAN_WORD0_ADDR, 32'h8a00_6011, rsp);
    axi_write(VLAN_WORD2_ADDR, 32'h0000_0006, rsp);
    tbl_act(ACT_WRITE, 12'h002);
    axi_write(VLAN_WORD0_ADDR, 32'h0000_0000, rsp);
    axi_write(VLAN_WORD2_ADDR, 32'h0000_0000, rsp);
    tbl_act(ACT_NONE, 12'h002);
    axi_read(VLAN_WORD0_ADDR, rd, rsp);
    chk_reg(rd, 32'h0000_0000);
    tbl_act(ACT_READ, 12'h002);
    axi_read(VLAN_WORD0_ADDR, rd, rsp);
    chk_reg(rd, 32'h8a00_6011);
    axi_read(VLAN_WORD2_ADDR, rd, rsp);
    chk_reg(rd, 32'h0000_0006);
    // Forwarding decisions
    frame(12'h001, 2'h0, 3'b011, 3'b001, 1'b0, 1'b0);
    chk_port(7'(fwd_map), 7'h01);
    chk_port(filter_identifier, 7'h2a);
    chk_port(7'(vprio), 7'h05);
    chk_port(7'(mst), 7'h03);
    frame(12'h002, 2'h0, 3'b001, 3'b111, 1'b0, 1'b0);
    chk_port(7'(fwd_map), 7'h06);
    chk_port(filter_identifier, 7'h11);
    axi_write(QUEUE_CTRL_ADDR, 32'h0000_0080, rsp);
    frame(12'h001, 2'h0, 3'b100, 3'b001, 1'b0, 1'b0);
    chk_port(7'(fwd_map), 7'h04);
    frame(12'h001, 2'h0, 3'b100, 3'b001, 1'b1, 1'b1);
    chk_port(7'(fwd_map), 7'h00);
    frame(12'h001, 2'h0, 3'b100, 3'b001, 1'b1, 1'b0);
    chk_port(7'(fwd_map), 7'h04);
    // Queue map codes P3, P23 and P123 against every priority
    for (int c = 0; c < 3; c++) begin
      axi_write(QUEUE_CTRL_ADDR, {24'h00_0000, codes[c], 6'h02}, rsp);
      for (int p = 0; p < 4; p++) begin
        frame(12'h001, 2'(p), 3'b001, 3'b001, 1'b0, 1'b0);
        chk_port(7'(high_q), 7'(p >= thr[c]));
      end
    end
    tbl_act(ACT_CLEAR, 12'h000);
    tbl_act(ACT_READ, 12'h002);
    axi_read(VLAN_WORD0_ADDR, rd, rsp);
    chk_reg(rd, 32'h0000_0000);
    tally_and_finish();
  end

  initial begin
    #500_000;
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule : tb
